// ==== core/oti_params.svh ====
// Constants for the over-travel inhibit block: offsets, fields, resets, limits
`ifndef OTI_PARAMS_SVH
`define OTI_PARAMS_SVH

// Register byte offsets
`define OTI_ADDR_MODE 8'h00
`define OTI_ADDR_FEXP 8'h04
`define OTI_ADDR_LEVEL 8'h08
`define OTI_ADDR_STATUS 8'h0C
`define OTI_ADDR_ISTAT 8'h10
`define OTI_ADDR_IMASK 8'h14

// Inhibit-mode setting values
`define OTI_MODE_SERVO 2'h0
`define OTI_MODE_PROFILE 2'h1
`define OTI_MODE_ALARM 2'h2

// Function-expansion bit that picks extended release conditions
`define OTI_FEXP_RELEASE_BIT 21

// Interrupt status and mask bit positions
`define OTI_IRQ_ALARM 0
`define OTI_IRQ_CFG 1
`define OTI_IRQ_PRISE 2
`define OTI_IRQ_NRISE 3
`define OTI_IRQ_REJ 4

// Reset values
`define OTI_MODE_RST 2'h0
`define OTI_FEXP_RST 32'h0000_0000
`define OTI_LEVEL_RST 32'h0000_0000
`define OTI_IMASK_RST 5'h00

// Motor treated as stopped below this speed, r/min
`define OTI_STOP_SPEED_RPM 16'h001E

`endif

// ==== core/oti_pkg.sv ====
// Types for the over-travel inhibit block
package oti_pkg;

    typedef enum logic [2:0] {
        OTI_ST_FREE = 3'h1,
        OTI_ST_LIMIT = 3'h2,
        OTI_ST_HOLD = 3'h4
    } oti_state_e;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
    } oti_sync_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [31:0] fexp;
        logic [31:0] level;
        logic [4:0] imask;
        logic [4:0] istat;
        oti_state_e st;
        logic pos_ok;
        logic neg_ok;
        logic lim_act;
        logic decel;
        logic stopped;
        logic cfg_err;
        logic acc;
        logic rej;
        logic irq;
        logic [31:0] rdata;
        logic plim_d;
        logic nlim_d;
    } oti_core_s;

endpackage : oti_pkg

// ==== core/oti_sync.sv ====
// Two-flop synchroniser for the two limit switch pins
`timescale 1ns/10ps
module oti_sync (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] pin_i,
    output logic [1:0] sync_o
);
    oti_pkg::oti_sync_s r;
    oti_pkg::oti_sync_s r_nxt;

    always_comb begin
        r_nxt = r;
        r_nxt.meta = pin_i;
        // First stage feeds the second stage only
        r_nxt.sync = r.meta;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign sync_o = r.sync;
endmodule : oti_sync

// ==== core/oti_core.sv ====
// Over-travel inhibit handling: limit inputs, direction blocking, release
//
// Notes on behaviour
// RL1 - Ignore commands toward inhibited direction only
// RL2 - Deceleration lasts until speed below 30 r/min
// RL3 - Mode 2: any limit raises over-travel alarm
// RL4 - Release level matters only in mode 1
// RL5 - Deviation at/above nonzero level blocks both directions
// RL6 - Mode not 1 with level nonzero: config error
// RL7 - Conventional release: block own side, then free
// RL8 - Expansion bit 21 selects extended release conditions
// RL9 - Limit active flag during deceleration and stop
// RL10 - Sample limits, decide blocking every cycle
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "oti_params.svh"
module oti_core (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic positive_limit_input_i,
    input wire logic negative_limit_input_i,
    input wire logic [31:0] position_deviation_i,
    input wire logic [15:0] motor_speed_rpm_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_positive_i,
    output logic cmd_accept_o,
    output logic cmd_reject_o,
    output logic positive_operable_o,
    output logic negative_operable_o,
    output logic internal_limit_active_o,
    output logic decelerating_o,
    output logic stopped_o,
    output logic overtravel_alarm_error_o,
    output logic release_config_error_o,
    output logic irq_o
);
    oti_pkg::oti_core_s r;
    oti_pkg::oti_core_s r_nxt;
    logic [1:0] lim_s;
    logic plim;
    logic nlim;

    // Magnitude of a two's complement deviation
    function automatic logic [31:0] oti_abs(input logic [31:0] d);
        oti_abs = d[31] ? (~d + 32'h0000_0001) : d;
    endfunction : oti_abs

    oti_sync u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i({negative_limit_input_i, positive_limit_input_i}),
        .sync_o(lim_s)
    );

    assign plim = lim_s[0];
    assign nlim = lim_s[1];

    always_comb begin
        logic any_lim;
        logic mode1;
        logic lvl_nz;
        logic dev_hi;
        logic slow;
        logic rel_ok;
        logic in_inh;
        logic alarm_set;
        logic both_blk;
        logic pos_blk;
        logic neg_blk;
        logic [4:0] ev;
        logic [4:0] clr;
        ev = '0;
        clr = '0;
        any_lim = plim | nlim;
        mode1 = (r.mode == `OTI_MODE_PROFILE);
        lvl_nz = (r.level != 32'h0000_0000);
        slow = (motor_speed_rpm_i < `OTI_STOP_SPEED_RPM); // RL2
        // Level only gates release in profile mode
        dev_hi = mode1 & lvl_nz
            & (oti_abs(position_deviation_i) >= r.level); // RL4 RL5
        // Extended release also waits for the motor to come to rest
        rel_ok = !dev_hi
            & (!r.fexp[`OTI_FEXP_RELEASE_BIT] | slow); // RL8
        in_inh = any_lim | (r.st != oti_pkg::OTI_ST_FREE);
        alarm_set = (r.mode == `OTI_MODE_ALARM) & any_lim; // RL3
        r_nxt = r;

        // Inhibit state tracking, evaluated each cycle
        unique case (r.st) // RL10
            oti_pkg::OTI_ST_FREE: begin
                if (any_lim) begin
                    r_nxt.st = oti_pkg::OTI_ST_LIMIT;
                end
            end
            oti_pkg::OTI_ST_LIMIT: begin
                if (!any_lim) begin
                    r_nxt.st = rel_ok ? oti_pkg::OTI_ST_FREE
                                      : oti_pkg::OTI_ST_HOLD; // RL7
                end
            end
            oti_pkg::OTI_ST_HOLD: begin
                if (any_lim) begin
                    r_nxt.st = oti_pkg::OTI_ST_LIMIT;
                end else if (rel_ok) begin
                    r_nxt.st = oti_pkg::OTI_ST_FREE; // RL5
                end
            end
            default: begin
                r_nxt.st = oti_pkg::OTI_ST_FREE;
            end
        endcase

        // While an alarm is pending nothing may move
        both_blk = alarm_set | r.istat[`OTI_IRQ_ALARM]
            | (any_lim & dev_hi) // RL5
            | (in_inh & !any_lim & !rel_ok); // RL5 RL8
        pos_blk = plim | both_blk; // RL1 RL7
        neg_blk = nlim | both_blk; // RL1 RL7
        r_nxt.pos_ok = !pos_blk;
        r_nxt.neg_ok = !neg_blk;

        // Commands toward a blocked side are dropped, not queued
        r_nxt.acc = cmd_valid_i
            & (cmd_positive_i ? !pos_blk : !neg_blk); // RL1
        r_nxt.rej = cmd_valid_i
            & (cmd_positive_i ? pos_blk : neg_blk); // RL1

        r_nxt.lim_act = any_lim
            & (r.mode == `OTI_MODE_SERVO | mode1); // RL9
        r_nxt.decel = r_nxt.lim_act & !slow; // RL2
        r_nxt.stopped = r_nxt.lim_act & slow; // RL2
        r_nxt.cfg_err = !mode1 & lvl_nz; // RL6
        r_nxt.plim_d = plim;
        r_nxt.nlim_d = nlim;

        ev[`OTI_IRQ_ALARM] = alarm_set; // RL3
        ev[`OTI_IRQ_CFG] = r_nxt.cfg_err; // RL6
        ev[`OTI_IRQ_PRISE] = plim & !r.plim_d;
        ev[`OTI_IRQ_NRISE] = nlim & !r.nlim_d;
        ev[`OTI_IRQ_REJ] = r_nxt.rej;

        // Register writes; interrupt status is write-one-to-clear
        if (wr_i) begin
            unique case (addr_i)
                `OTI_ADDR_MODE: r_nxt.mode = wdata_i[1:0];
                `OTI_ADDR_FEXP: r_nxt.fexp = wdata_i;
                `OTI_ADDR_LEVEL: r_nxt.level = wdata_i;
                `OTI_ADDR_ISTAT: clr = wdata_i[4:0];
                `OTI_ADDR_IMASK: r_nxt.imask = wdata_i[4:0];
                default: begin
                end
            endcase
        end
        // A new event in the clearing cycle survives the clear
        r_nxt.istat = (r.istat & ~clr) | ev;
        r_nxt.irq = |(r_nxt.istat & r_nxt.imask);

        r_nxt.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                `OTI_ADDR_MODE: r_nxt.rdata = {30'h0, r.mode};
                `OTI_ADDR_FEXP: r_nxt.rdata = r.fexp;
                `OTI_ADDR_LEVEL: r_nxt.rdata = r.level;
                `OTI_ADDR_STATUS: r_nxt.rdata = {19'h0, r.st, r.cfg_err,
                    r.acc, r.rej, r.stopped, r.decel, r.lim_act,
                    r.neg_ok, r.pos_ok, nlim, plim};
                `OTI_ADDR_ISTAT: r_nxt.rdata = {27'h0, r.istat};
                `OTI_ADDR_IMASK: r_nxt.rdata = {27'h0, r.imask};
                default: r_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.mode <= `OTI_MODE_RST;
            r.fexp <= `OTI_FEXP_RST;
            r.level <= `OTI_LEVEL_RST;
            r.imask <= `OTI_IMASK_RST;
            r.st <= oti_pkg::OTI_ST_FREE;
        end else begin
            r <= r_nxt;
        end
    end

    assign rdata_o = r.rdata;
    assign cmd_accept_o = r.acc;
    assign cmd_reject_o = r.rej;
    assign positive_operable_o = r.pos_ok;
    assign negative_operable_o = r.neg_ok;
    assign internal_limit_active_o = r.lim_act;
    assign decelerating_o = r.decel;
    assign stopped_o = r.stopped;
    assign overtravel_alarm_error_o = r.istat[`OTI_IRQ_ALARM];
    assign release_config_error_o = r.cfg_err;
    assign irq_o = r.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_rej_pos;
        cmd_valid_i && cmd_positive_i && plim |=> cmd_reject_o
            && !cmd_accept_o;
    endproperty
    a_rej_pos: assert property (p_rej_pos) // RL1
        else $error("command toward active positive limit not rejected");

    property p_acc_other;
        cmd_valid_i && !cmd_positive_i && plim && !nlim
            && r.mode == `OTI_MODE_SERVO && r.level == 32'h0
            && !r.istat[`OTI_IRQ_ALARM] |=> cmd_accept_o;
    endproperty
    a_acc_other: assert property (p_acc_other) // RL1
        else $error("command away from limit not accepted");

    property p_stop_slow;
        r.mode == `OTI_MODE_PROFILE && plim
            && motor_speed_rpm_i < 16'h001E |=> stopped_o && !decelerating_o;
    endproperty
    a_stop_slow: assert property (p_stop_slow) // RL2
        else $error("slow motor under limit not treated as stopped");

    property p_decel_fast;
        r.mode == `OTI_MODE_SERVO && nlim
            && motor_speed_rpm_i >= 16'h001E |=> decelerating_o;
    endproperty
    a_decel_fast: assert property (p_decel_fast) // RL2
        else $error("fast motor under limit not decelerating");

    property p_alarm;
        r.mode == `OTI_MODE_ALARM && (plim || nlim) |=> ##[0:1]
            (overtravel_alarm_error_o && !positive_operable_o
            && !negative_operable_o);
    endproperty
    a_alarm: assert property (p_alarm) // RL3
        else $error("limit in alarm mode did not raise alarm");

    property p_level_ignored;
        r.mode == `OTI_MODE_SERVO && r.level != 32'h0 && plim && !nlim
            && !r.istat[`OTI_IRQ_ALARM] |=> negative_operable_o;
    endproperty
    a_level_ignored: assert property (p_level_ignored) // RL4
        else $error("release level acted outside profile mode");

    property p_dev_hold;
        r.mode == `OTI_MODE_PROFILE && r.level != 32'h0 && (plim || nlim)
            && oti_abs(position_deviation_i) >= r.level
            |=> !positive_operable_o && !negative_operable_o;
    endproperty
    a_dev_hold: assert property (p_dev_hold) // RL5
        else $error("large deviation did not block both directions");

    property p_cfg_err;
        r.mode != `OTI_MODE_PROFILE && r.level != 32'h0
            |=> release_config_error_o ##1 r.istat[`OTI_IRQ_CFG];
    endproperty
    a_cfg_err: assert property (p_cfg_err) // RL6
        else $error("config error not raised");

    property p_conv_free;
        r.mode == `OTI_MODE_PROFILE && r.level == 32'h0 && !plim && !nlim
            && !r.fexp[`OTI_FEXP_RELEASE_BIT] && !r.istat[`OTI_IRQ_ALARM]
            |=> positive_operable_o && negative_operable_o;
    endproperty
    a_conv_free: assert property (p_conv_free) // RL7
        else $error("released limit still blocks in conventional mode");

    property p_ext_wait;
        r.mode == `OTI_MODE_PROFILE && r.fexp[`OTI_FEXP_RELEASE_BIT]
            && !plim && !nlim && r.st != oti_pkg::OTI_ST_FREE
            && motor_speed_rpm_i >= 16'h001E |=> !positive_operable_o;
    endproperty
    a_ext_wait: assert property (p_ext_wait) // RL8
        else $error("extended release freed a moving motor");

    property p_bit11;
        r.mode != `OTI_MODE_ALARM && r.mode != 2'h3 && (plim || nlim)
            |=> internal_limit_active_o;
    endproperty
    a_bit11: assert property (p_bit11) // RL9
        else $error("limit active flag missing");

    property p_sample;
        resetn_i && $past(resetn_i) && $past(resetn_i, 2)
            |-> plim == $past(positive_limit_input_i, 2);
    endproperty
    a_sample: assert property (p_sample) // RL10
        else $error("positive limit not sampled through two stages");
endmodule : oti_core

// ==== test/oti_far.sv ====
// Far-side model: limit switches and the motion command source
`timescale 1ns/10ps
module oti_far (
    input wire logic clk_i,
    output logic pos_lim_o,
    output logic neg_lim_o,
    output logic cmd_valid_o,
    output logic cmd_positive_o
);
    initial begin
        pos_lim_o = 1'h0;
        neg_lim_o = 1'h0;
        cmd_valid_o = 1'h0;
        cmd_positive_o = 1'h0;
    end

    task automatic set_lim(input logic p, input logic n);
        @(posedge clk_i);
        pos_lim_o <= p;
        neg_lim_o <= n;
    endtask : set_lim

    // Direction flips once the command is gone, so a stale value never helps
    task automatic cmd(input logic dir);
        @(posedge clk_i);
        cmd_valid_o <= 1'h1;
        cmd_positive_o <= dir;
        @(posedge clk_i);
        cmd_valid_o <= 1'h0;
        cmd_positive_o <= ~dir;
    endtask : cmd
endmodule : oti_far

// ==== test/overtravel_inhibit_release_bench.sv ====
// Self-checking bench for the over-travel inhibit block
`timescale 1ns/10ps
`include "oti_params.svh"
module overtravel_inhibit_release_bench;
    typedef struct packed {
        logic [1:0] mode;
        logic [31:0] lvl;
        logic [31:0] dev;
        logic pl;
        logic nl;
        logic [4:0] exp;
    } oti_row_s;

    // Expect: pos_ok, neg_ok, limit flag, alarm, config error
    localparam oti_row_s ROWS [11] = '{
        '{2'h0, 32'h0, 32'h0, 1'h1, 1'h0, 5'h0C},
        '{2'h0, 32'h0, 32'h0, 1'h0, 1'h1, 5'h14},
        '{2'h1, 32'h0, 32'h0, 1'h1, 1'h0, 5'h0C},
        '{2'h1, 32'h64, 32'h64, 1'h1, 1'h0, 5'h04},
        '{2'h1, 32'h64, 32'h63, 1'h1, 1'h0, 5'h0C},
        '{2'h1, 32'h64, 32'hFFFFFF9C, 1'h0, 1'h1, 5'h04},
        '{2'h1, 32'h64, 32'hFFFFFF9D, 1'h0, 1'h1, 5'h14},
        '{2'h0, 32'h64, 32'hC8, 1'h1, 1'h0, 5'h0D},
        '{2'h2, 32'h0, 32'h0, 1'h1, 1'h0, 5'h02},
        '{2'h2, 32'h0, 32'h0, 1'h0, 1'h1, 5'h02},
        '{2'h2, 32'h64, 32'h0, 1'h0, 1'h1, 5'h03}
    };
    localparam logic [7:0] RADDR [7] = '{`OTI_ADDR_MODE, `OTI_ADDR_FEXP,
        `OTI_ADDR_LEVEL, `OTI_ADDR_STATUS, `OTI_ADDR_ISTAT, `OTI_ADDR_IMASK,
        8'h18};
    localparam logic [31:0] RRST [7] = '{32'h0, 32'h0, 32'h0, 32'h40C,
        32'h0, 32'h0, 32'h0};

    logic clk_i = 1'h0;
    logic resetn_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rdata_o;
    logic plim;
    logic nlim;
    logic [31:0] position_deviation_i;
    logic [15:0] motor_speed_rpm_i;
    logic cmd_valid;
    logic cmd_pos;
    logic cmd_accept_o;
    logic cmd_reject_o;
    logic positive_operable_o;
    logic negative_operable_o;
    logic internal_limit_active_o;
    logic decelerating_o;
    logic stopped_o;
    logic overtravel_alarm_error_o;
    logic release_config_error_o;
    logic irq_o;
    logic [31:0] rd_v;
    int error_cnt = 0;
    int checks = 0;
    wire logic [4:0] obs = {positive_operable_o, negative_operable_o,
        internal_limit_active_o, overtravel_alarm_error_o,
        release_config_error_o};

    always #50 clk_i = ~clk_i;

    oti_far far (
        .clk_i(clk_i),
        .pos_lim_o(plim),
        .neg_lim_o(nlim),
        .cmd_valid_o(cmd_valid),
        .cmd_positive_o(cmd_pos)
    );

    oti_core DUT (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .positive_limit_input_i(plim),
        .negative_limit_input_i(nlim),
        .position_deviation_i(position_deviation_i),
        .motor_speed_rpm_i(motor_speed_rpm_i),
        .cmd_valid_i(cmd_valid),
        .cmd_positive_i(cmd_pos),
        .cmd_accept_o(cmd_accept_o),
        .cmd_reject_o(cmd_reject_o),
        .positive_operable_o(positive_operable_o),
        .negative_operable_o(negative_operable_o),
        .internal_limit_active_o(internal_limit_active_o),
        .decelerating_o(decelerating_o),
        .stopped_o(stopped_o),
        .overtravel_alarm_error_o(overtravel_alarm_error_o),
        .release_config_error_o(release_config_error_o),
        .irq_o(irq_o)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        d = rdata_o;
    endtask : rd

    // Pins pass two sync flops plus the decision register
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        resetn_i = 1'h0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        wr_i = 1'h0;
        rd_i = 1'h0;
        position_deviation_i = 32'h0;
        motor_speed_rpm_i = 16'h0000;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'h1;
        for (int i = 0; i < 11; i++) begin
            wr(`OTI_ADDR_MODE, {30'h0, ROWS[i].mode});
            wr(`OTI_ADDR_LEVEL, ROWS[i].lvl);
            position_deviation_i <= ROWS[i].dev;
            far.set_lim(ROWS[i].pl, ROWS[i].nl);
            settle();
            chk(obs, ROWS[i].exp);
            far.set_lim(1'h0, 1'h0);
            position_deviation_i <= 32'h0;
            wr(`OTI_ADDR_LEVEL, 32'h0);
            wr(`OTI_ADDR_MODE, 32'h0);
            wr(`OTI_ADDR_ISTAT, 32'h1F);
            settle();
            chk(obs, 5'h18);
        end
        // Limit gone but deviation still high: both sides stay blocked
        wr(`OTI_ADDR_MODE, 32'h1);
        wr(`OTI_ADDR_LEVEL, 32'h64);
        position_deviation_i <= 32'h96;
        far.set_lim(1'h1, 1'h0);
        settle();
        far.set_lim(1'h0, 1'h0);
        settle();
        chk(obs, 5'h00);
        position_deviation_i <= 32'h32;
        settle();
        chk(obs, 5'h18);
        wr(`OTI_ADDR_FEXP, 32'h0020_0000);
        motor_speed_rpm_i <= `OTI_STOP_SPEED_RPM;
        far.set_lim(1'h1, 1'h0);
        settle();
        chk({decelerating_o, stopped_o}, 2'h2);
        motor_speed_rpm_i <= 16'h001D;
        settle();
        chk({decelerating_o, stopped_o}, 2'h1);
        motor_speed_rpm_i <= 16'h0064;
        far.set_lim(1'h0, 1'h0);
        settle();
        chk(obs, 5'h00);
        motor_speed_rpm_i <= 16'h0000;
        settle();
        chk(obs, 5'h18);
        wr(`OTI_ADDR_FEXP, 32'h0);
        wr(`OTI_ADDR_LEVEL, 32'h0);
        wr(`OTI_ADDR_MODE, 32'h0);
        wr(`OTI_ADDR_ISTAT, 32'h1F);
        wr(`OTI_ADDR_IMASK, 32'h10);
        far.set_lim(1'h1, 1'h0);
        settle();
        far.cmd(1'h1);
        #1;
        chk({cmd_accept_o, cmd_reject_o}, 2'h1);
        far.cmd(1'h0);
        #1;
        chk({cmd_accept_o, cmd_reject_o}, 2'h2);
        settle();
        chk(irq_o, 1'h1);
        rd(`OTI_ADDR_ISTAT, rd_v);
        chk(rd_v, 32'h14);
        wr(`OTI_ADDR_IMASK, 32'h0);
        settle();
        chk(irq_o, 1'h0);
        motor_speed_rpm_i <= 16'h0064;
        far.set_lim(1'h0, 1'h1);
        settle();
        chk({decelerating_o, stopped_o}, 2'h2);
        far.cmd(1'h0);
        #1;
        chk({cmd_accept_o, cmd_reject_o}, 2'h1);
        motor_speed_rpm_i <= 16'h0000;
        far.set_lim(1'h0, 1'h0);
        wr(`OTI_ADDR_ISTAT, 32'h1F);
        wr(`OTI_ADDR_IMASK, 32'h10);
        settle();
        chk(irq_o, 1'h0);
        // Mid-run reset must wipe a written register
        wr(`OTI_ADDR_LEVEL, 32'hA5A55A5A);
        rd(`OTI_ADDR_LEVEL, rd_v);
        chk(rd_v, 32'hA5A55A5A);
        resetn_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({obs, irq_o}, 6'h00);
        resetn_i <= 1'h1;
        for (int j = 0; j < 7; j++) begin
            rd(RADDR[j], rd_v);
            chk(rd_v, RRST[j]);
        end
        end_of_test();
    end
endmodule : overtravel_inhibit_release_bench
